// file: hw/rtc_pkg.sv
package rtc_pkg;
    // timebase
    localparam int XTAL_HZ = 32768;
    localparam int SEC_DIV = 32768;
    localparam int LAST_YEAR = 2099;
    localparam int BASE_YEAR = 2000;
    // glitch filter times in microseconds, counts in crystal ticks (least time, rounded up)
    localparam int FILT1_US = 3900;
    localparam int FILT2_US = 15200;
    localparam int FILT3_US = 31250;
    localparam logic [10:0] FILT1_TICKS = 11'((FILT1_US * 64'(XTAL_HZ) + 999999) / 1000000);
    localparam logic [10:0] FILT2_TICKS = 11'((FILT2_US * 64'(XTAL_HZ) + 999999) / 1000000);
    localparam logic [10:0] FILT3_TICKS = 11'((FILT3_US * 64'(XTAL_HZ) + 999999) / 1000000);
    // sampling periods in crystal ticks: 2 Hz, 1 Hz, 1/4 Hz
    localparam logic [17:0] SMP_2HZ_TICKS = 18'(XTAL_HZ / 2);
    localparam logic [17:0] SMP_1HZ_TICKS = 18'(XTAL_HZ);
    localparam logic [17:0] SMP_QHZ_TICKS = 18'(XTAL_HZ * 4);
    // select encodings
    localparam logic [1:0] SMP_ALWAYS = 2'h0;
    localparam logic [1:0] SMP_2HZ = 2'h1;
    localparam logic [1:0] SMP_1HZ = 2'h2;
    localparam logic [1:0] SMP_QHZ = 2'h3;
    localparam logic [3:0] FREQ_OUTPUT_IRQ = 4'h0;
    localparam logic [3:0] FREQ_OUTPUT_XTAL = 4'h1;
    // alarm enable mask bit positions
    localparam int AEN_SEC = 0;
    localparam int AEN_MIN = 1;
    localparam int AEN_HOUR = 2;
    localparam int AEN_DATE = 3;
    localparam int AEN_MONTH = 4;
    localparam int AEN_DOW = 5;
    // calendar limits and reset values
    localparam logic [5:0] SEC_MAX = 6'h3b;
    localparam logic [5:0] MIN_MAX = 6'h3b;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [3:0] MONTH_MAX = 4'hc;
    localparam logic [6:0] YEAR_MAX = 7'(LAST_YEAR - BASE_YEAR);
    localparam logic [2:0] DOW_MAX = 3'h6;

    typedef struct packed {
        logic [5:0] sec;
        logic [5:0] min;
        logic [4:0] hour;
        logic [4:0] date;
        logic [3:0] month;
        logic [6:0] year;
        logic [2:0] dow;
    } rtc_time_t;

    localparam rtc_time_t TIME_RST = '{sec: 6'h00, min: 6'h00, hour: 5'h00, date: 5'h01,
                                       month: 4'h1, year: 7'h00, dow: 3'h0};

    typedef enum logic [0:0] {
        PWR_MAIN = 1'b0,
        PWR_BACKUP = 1'b1
    } pwr_state_t;
endpackage : rtc_pkg

// file: hw/rtc_event_alarm_power_switch.sv
// Contract
// - a valid high on the tamper input sets the sticky event flag
// - optionally signal detected events on the dedicated detect output
// - optionally freeze time registers when an event is detected
// - detect output is open drain, low until event flag cleared or event enable dropped
// - event enable gates the tamper input; disabled means no detections
// - detection works in main and backup; option decides backup operation
// - input may be sampled periodically at selectable rates
// - input must stay high for selected filter time: 0, 3.9, 15.2, 31.25 ms
// - alarm matches enabled calendar fields against current time
// - alarm match sets readable status and optionally the interrupt
// - repeat mode re-triggers the alarm periodically
// - frequency-out select picks interrupt or frequency on shared pin
// - interrupt mode: shared pin is open drain active low
// - frequency mode: shared pin outputs selected crystal-derived clock
// - serial interface disabled while running from backup supply
// - serial bus runs up to 400kHz; host must not exceed that
// - switch to backup only when below backup-hys and below trip
// - return to main when above backup+hys or above trip+hys
// - separate time counters with leap-year correction through 2099
// - timebase is a 32.768kHz crystal or external clock on crystal input
`timescale 1ns/10ps
module rtc_event_alarm_power_switch
    import rtc_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // pins
    input wire logic crystal_input_i,
    input wire logic tamper_input_i,
    output logic tamper_detect_out_o,
    output logic tamper_detect_oe_o,
    output logic irq_freq_o,
    output logic irq_freq_oe_o,
    // supply comparator flags
    input wire logic vdd_below_bat_i,
    input wire logic vdd_below_trip_i,
    input wire logic vdd_above_bat_hys_i,
    input wire logic vdd_above_trip_hys_i,
    // event control
    input wire logic event_enable_i,
    input wire logic tamper_backup_option_i,
    input wire logic detect_out_enable_i,
    input wire logic freeze_enable_i,
    input wire logic [1:0] tamper_filter_select_i,
    input wire logic [1:0] sample_rate_i,
    input wire logic event_flag_clear_i,
    // alarm control
    input wire rtc_time_t alarm_time_i,
    input wire logic [5:0] alarm_field_enable_i,
    input wire logic alarm_arm_i,
    input wire logic alarm_repeat_i,
    input wire logic irq_enable_i,
    input wire logic alarm_flag_clear_i,
    input wire logic [3:0] freq_output_select_i,
    // time set and status
    input wire logic time_load_i,
    input wire rtc_time_t time_set_i,
    output rtc_time_t time_o,
    output logic event_flag_o,
    output logic alarm_flag_o,
    output logic backup_mode_o,
    output logic serial_enable_o
);

    // ----------------------------------------
    // calendar functions
    // ----------------------------------------
    function automatic logic [4:0] days_in_month(input logic [3:0] month, input logic [6:0] year);
        logic [4:0] d;
        d = 5'h1f;
        unique case (month)
            4'h4, 4'h6, 4'h9, 4'hb: d = 5'h1e;
            // year 2000 is a leap year, so divisible by four holds through 2099
            4'h2: d = (year[1:0] == 2'h0) ? 5'h1d : 5'h1c;
            default: d = 5'h1f;
        endcase
        return d;
    endfunction : days_in_month

    function automatic rtc_time_t advance(input rtc_time_t t);
        rtc_time_t n;
        n = t;
        if (t.sec < SEC_MAX) begin
            n.sec = t.sec + 6'h01;
        end else begin
            n.sec = 6'h00;
            if (t.min < MIN_MAX) begin
                n.min = t.min + 6'h01;
            end else begin
                n.min = 6'h00;
                if (t.hour < HOUR_MAX) begin
                    n.hour = t.hour + 5'h01;
                end else begin
                    n.hour = 5'h00;
                    n.dow = (t.dow < DOW_MAX) ? t.dow + 3'h1 : 3'h0;
                    if (t.date < days_in_month(t.month, t.year)) begin
                        n.date = t.date + 5'h01;
                    end else begin
                        n.date = 5'h01;
                        if (t.month < MONTH_MAX) begin
                            n.month = t.month + 4'h1;
                        end else begin
                            n.month = 4'h1;
                            n.year = (t.year < YEAR_MAX) ? t.year + 7'h01 : 7'h00;
                        end
                    end
                end
            end
        end
        return n;
    endfunction : advance

    // ----------------------------------------
    // synchronisers and timebase
    // ----------------------------------------
    logic [1:0] xtal_sync_reg;
    logic [1:0] tamper_sync_reg;
    logic [3:0] sup_sync1_reg;
    logic [3:0] sup_sync2_reg;
    logic xtal_prev_reg;
    logic [14:0] prescale_reg;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            xtal_sync_reg <= 2'h0;
            tamper_sync_reg <= 2'h0;
            sup_sync1_reg <= 4'h0;
            sup_sync2_reg <= 4'h0;
            xtal_prev_reg <= 1'b0;
        end else begin
            xtal_sync_reg <= {xtal_sync_reg[0], crystal_input_i};
            tamper_sync_reg <= {tamper_sync_reg[0], tamper_input_i};
            sup_sync1_reg <= {vdd_above_trip_hys_i, vdd_above_bat_hys_i, vdd_below_trip_i, vdd_below_bat_i};
            sup_sync2_reg <= sup_sync1_reg;
            xtal_prev_reg <= xtal_sync_reg[1];
        end
    end

    wire xtal_tick = xtal_sync_reg[1] & ~xtal_prev_reg;
    wire sec_tick = xtal_tick && (prescale_reg == 15'(SEC_DIV - 1));

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            prescale_reg <= 15'h0000;
        end else if (xtal_tick) begin
            prescale_reg <= prescale_reg + 15'h0001;
        end
    end

    // ----------------------------------------
    // supply switchover
    // ----------------------------------------
    pwr_state_t pwr_reg;
    pwr_state_t pwr_next;
    wire below_bat = sup_sync2_reg[0];
    wire below_trip = sup_sync2_reg[1];
    wire above_bat = sup_sync2_reg[2];
    wire above_trip = sup_sync2_reg[3];

    always_comb begin
        pwr_next = pwr_reg;
        unique case (pwr_reg)
            PWR_MAIN: if (below_bat && below_trip) pwr_next = PWR_BACKUP;
            PWR_BACKUP: if (above_bat || above_trip) pwr_next = PWR_MAIN;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pwr_reg <= PWR_MAIN;
        end else begin
            pwr_reg <= pwr_next;
        end
    end

    wire in_backup = (pwr_reg == PWR_BACKUP);
    assign backup_mode_o = in_backup;
    assign serial_enable_o = ~in_backup;

    // ----------------------------------------
    // event monitor
    // ----------------------------------------
    logic [17:0] smp_phase_reg;
    logic [10:0] filt_cnt_reg;
    logic event_flag_reg;

    wire det_active = event_enable_i && (~in_backup || tamper_backup_option_i);
    wire [10:0] filt_thresh = (tamper_filter_select_i == 2'h1) ? FILT1_TICKS :
                              (tamper_filter_select_i == 2'h2) ? FILT2_TICKS :
                              (tamper_filter_select_i == 2'h3) ? FILT3_TICKS : 11'h000;
    // sample period; window covers the filter time plus one tick
    wire [17:0] smp_period = (sample_rate_i == SMP_2HZ) ? SMP_2HZ_TICKS :
                             (sample_rate_i == SMP_1HZ) ? SMP_1HZ_TICKS : SMP_QHZ_TICKS;
    wire smp_window = (sample_rate_i == SMP_ALWAYS) || (smp_phase_reg <= {7'h00, filt_thresh});
    wire gated_in = tamper_sync_reg[1] && det_active && smp_window;
    wire det_valid = gated_in && (filt_cnt_reg >= filt_thresh);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            smp_phase_reg <= 18'h00000;
            filt_cnt_reg <= 11'h000;
        end else begin
            if (xtal_tick) begin
                smp_phase_reg <= (smp_phase_reg >= smp_period - 18'h00001) ? 18'h00000 : smp_phase_reg + 18'h00001;
            end
            if (!gated_in) begin
                filt_cnt_reg <= 11'h000;
            end else if (xtal_tick && filt_cnt_reg < filt_thresh) begin
                filt_cnt_reg <= filt_cnt_reg + 11'h001;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            event_flag_reg <= 1'b0;
        end else begin
            event_flag_reg <= det_valid | (event_flag_reg & ~event_flag_clear_i);
        end
    end

    assign event_flag_o = event_flag_reg;
    assign tamper_detect_out_o = 1'b0;
    assign tamper_detect_oe_o = detect_out_enable_i && event_enable_i && event_flag_reg;

    // ----------------------------------------
    // timekeeper
    // ----------------------------------------
    rtc_time_t time_reg;
    // freeze from detection until flag cleared
    wire halt = freeze_enable_i && (event_flag_reg || det_valid);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            time_reg <= TIME_RST;
        end else if (time_load_i) begin
            time_reg <= time_set_i;
        end else if (sec_tick && !halt) begin
            time_reg <= advance(time_reg);
        end
    end

    assign time_o = time_reg;

    // ----------------------------------------
    // alarm and shared pin
    // ----------------------------------------
    logic alarm_armed_reg;
    logic alarm_match_prev_reg;
    logic alarm_flag_reg;

    wire [5:0] field_eq = {time_reg.dow == alarm_time_i.dow, time_reg.month == alarm_time_i.month,
                           time_reg.date == alarm_time_i.date, time_reg.hour == alarm_time_i.hour,
                           time_reg.min == alarm_time_i.min, time_reg.sec == alarm_time_i.sec};
    wire alarm_match = ((field_eq | ~alarm_field_enable_i) == 6'h3f) && (alarm_field_enable_i != 6'h00);
    wire alarm_hit = alarm_match && !alarm_match_prev_reg && alarm_armed_reg;

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            alarm_armed_reg <= 1'b0;
            alarm_match_prev_reg <= 1'b0;
            alarm_flag_reg <= 1'b0;
        end else begin
            alarm_match_prev_reg <= alarm_match;
            // single mode disarms after a hit, repeat stays armed
            if (alarm_arm_i) begin
                alarm_armed_reg <= 1'b1;
            end else if (alarm_hit && !alarm_repeat_i) begin
                alarm_armed_reg <= 1'b0;
            end
            alarm_flag_reg <= alarm_hit | (alarm_flag_reg & ~alarm_flag_clear_i);
        end
    end

    assign alarm_flag_o = alarm_flag_reg;

    // selection 1 is the crystal, higher selections halve per step
    wire [3:0] div_idx = freq_output_select_i - 4'h2;
    // padded so every index of the select stays inside the vector
    wire [15:0] div_taps = {1'b0, prescale_reg};
    wire freq_level = (freq_output_select_i == FREQ_OUTPUT_XTAL) ? xtal_sync_reg[1] : div_taps[div_idx];
    assign irq_freq_o = 1'b0;
    assign irq_freq_oe_o = (freq_output_select_i == FREQ_OUTPUT_IRQ) ? (irq_enable_i && alarm_flag_reg) : ~freq_level;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    event_flag_set_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        det_valid |=> event_flag_reg)
        else $error("event flag not set after detection");
    detect_pin_low_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(event_flag_reg) && detect_out_enable_i && event_enable_i |-> tamper_detect_oe_o)
        else $error("detect output not pulled low");
    time_frozen_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        halt && !time_load_i |=> time_reg == $past(time_reg))
        else $error("time advanced while frozen");
    disabled_quiet_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !event_enable_i |-> !det_valid)
        else $error("detection while disabled");
    backup_gate_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        in_backup && !tamper_backup_option_i |-> ##1 !$rose(event_flag_reg) || event_flag_clear_i)
        else $error("detection in backup without option");
    filter_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(det_valid) && tamper_filter_select_i != 2'h0 && $stable(tamper_filter_select_i) |-> $past(gated_in))
        else $error("filter passed a short pulse");
    alarm_status_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        alarm_hit |=> alarm_flag_reg)
        else $error("alarm status not recorded");
    irq_pin_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        freq_output_select_i == FREQ_OUTPUT_IRQ && irq_enable_i && alarm_flag_reg |-> irq_freq_oe_o && !irq_freq_o)
        else $error("interrupt pin not asserted");
    serial_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        $rose(in_backup) |-> !serial_enable_o ##1 !serial_enable_o || !in_backup)
        else $error("serial interface active in backup");
    to_backup_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        pwr_reg == PWR_MAIN ##1 pwr_reg == PWR_BACKUP |-> $past(below_bat) && $past(below_trip))
        else $error("backup entered without both conditions");
    to_main_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        pwr_reg == PWR_BACKUP && (above_bat || above_trip) |=> pwr_reg == PWR_MAIN)
        else $error("main supply not restored");
    sec_count_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        sec_tick && !halt && !time_load_i && time_reg.sec < SEC_MAX |=> time_reg.sec == $past(time_reg.sec) + 6'h01)
        else $error("seconds did not advance");

endmodule : rtc_event_alarm_power_switch

// file: tb/rtc_pin_env.sv
`timescale 1ns/10ps
module rtc_pin_env (
    // clock and control
    input wire logic mclk_i,
    input wire logic xtal_run_i,
    input wire logic [15:0] vdd_mv_i,
    input wire logic [15:0] bat_mv_i,
    // pins towards the device
    output logic crystal_input_o = 1'h0,
    output logic vdd_below_bat_o,
    output logic vdd_below_trip_o,
    output logic vdd_above_bat_hys_o,
    output logic vdd_above_trip_hys_o
);
    localparam int TRIP_MV = 2200;
    localparam int TRIP_HYS_MV = 30;
    localparam int BAT_HYS_MV = 50;

    // -----------------------------
    // crystal source
    // -----------------------------
    // external clock drive
    // sped up far beyond 32.768kHz, and still between runs so the prescaler stays known
    always @(posedge mclk_i) begin
        if (xtal_run_i) begin
            crystal_input_o <= ~crystal_input_o;
        end
    end

    // -----------------------------
    // supply comparators
    // -----------------------------
    // comparator thresholds
    assign vdd_below_bat_o = int'(vdd_mv_i) + BAT_HYS_MV < int'(bat_mv_i);
    assign vdd_below_trip_o = int'(vdd_mv_i) < TRIP_MV;
    assign vdd_above_bat_hys_o = int'(vdd_mv_i) > int'(bat_mv_i) + BAT_HYS_MV;
    assign vdd_above_trip_hys_o = int'(vdd_mv_i) > TRIP_MV + TRIP_HYS_MV;
endmodule : rtc_pin_env

// file: tb/rtc_event_alarm_power_switch_bench.sv
`timescale 1ns/10ps
module rtc_event_alarm_power_switch_bench import rtc_pkg::*;;
    logic mclk_i = 1'h0, sys_rst_i = 1'h1, time_load_i = 1'h0, xtal_run = 1'h0;
    logic crystal_input_i, vdd_below_bat_i, vdd_below_trip_i, vdd_above_bat_hys_i, vdd_above_trip_hys_i;
    logic tamper_input_i = 1'h0, event_enable_i = 1'h1, tamper_backup_option_i = 1'h0, detect_out_enable_i = 1'h0;
    logic freeze_enable_i = 1'h0, event_flag_clear_i = 1'h0, alarm_arm_i = 1'h0, alarm_repeat_i = 1'h0;
    logic irq_enable_i = 1'h0, alarm_flag_clear_i = 1'h0, prev;
    logic [1:0] tamper_filter_select_i = 2'h0, sample_rate_i = 2'h0;
    logic [5:0] alarm_field_enable_i = 6'h00;
    logic [3:0] freq_output_select_i = 4'h0;
    rtc_time_t alarm_time_i = '0, time_set_i = '0, time_o, t_base, t_hit, t_exp;
    logic tamper_detect_out_o, tamper_detect_oe_o, irq_freq_o, irq_freq_oe_o;
    logic event_flag_o, alarm_flag_o, backup_mode_o, serial_enable_o;
    logic [31:0] seed = 32'h0000f7ab;
    int n_fail = 0, checks = 0, cyc_cnt = 0, i, thr, nt, vdd_mv = 3300, bat_mv = 3000;

    initial forever #2 mclk_i = ~mclk_i;

    rtc_event_alarm_power_switch DUT (.mclk_i, .sys_rst_i, .crystal_input_i, .tamper_input_i,
        .tamper_detect_out_o, .tamper_detect_oe_o, .irq_freq_o, .irq_freq_oe_o, .vdd_below_bat_i,
        .vdd_below_trip_i, .vdd_above_bat_hys_i, .vdd_above_trip_hys_i, .event_enable_i,
        .tamper_backup_option_i, .detect_out_enable_i, .freeze_enable_i, .tamper_filter_select_i,
        .sample_rate_i, .event_flag_clear_i, .alarm_time_i, .alarm_field_enable_i, .alarm_arm_i,
        .alarm_repeat_i, .irq_enable_i, .alarm_flag_clear_i, .freq_output_select_i, .time_load_i,
        .time_set_i, .time_o, .event_flag_o, .alarm_flag_o, .backup_mode_o, .serial_enable_o);

    rtc_pin_env env (.mclk_i, .xtal_run_i(xtal_run), .vdd_mv_i(16'(vdd_mv)), .bat_mv_i(16'(bat_mv)),
        .crystal_input_o(crystal_input_i), .vdd_below_bat_o(vdd_below_bat_i),
        .vdd_below_trip_o(vdd_below_trip_i), .vdd_above_bat_hys_o(vdd_above_bat_hys_i),
        .vdd_above_trip_hys_o(vdd_above_trip_hys_i));

    // -----------------------------
    // reference model and helpers
    // -----------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // calendar step; every year of 2000..2099 divisible by four is a leap year
    function automatic rtc_time_t next_sec(rtc_time_t t);
        int s = int'(t.sec) + 1, m = t.min, h = t.hour, d = t.date, mo = t.month, y = t.year, w = t.dow;
        int dim = (mo == 2) ? ((y % 4 == 0) ? 29 : 28) : (mo == 4 || mo == 6 || mo == 9 || mo == 11) ? 30 : 31;
        if (s == 60) begin
            s = 0;
            m++;
        end
        if (m == 60) begin
            m = 0;
            h++;
        end
        if (h == 24) begin
            h = 0;
            d++;
            w = (w + 1) % 7;
        end
        if (d > dim) begin
            d = 1;
            mo++;
        end
        return '{sec: 6'(s), min: 6'(m), hour: 5'(h), date: 5'(d), month: 4'(mo), year: 7'(y), dow: 3'(w)};
    endfunction : next_sec

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : cyc

    task automatic load(input rtc_time_t t);
        time_set_i = t;
        time_load_i = 1'h1;
        cyc(1);
        time_load_i = 1'h0;
    endtask : load

    task automatic clr_flags();
        event_flag_clear_i = 1'h1;
        alarm_flag_clear_i = 1'h1;
        cyc(1);
        event_flag_clear_i = 1'h0;
        alarm_flag_clear_i = 1'h0;
        cyc(1);
    endtask : clr_flags

    task automatic arm();
        alarm_arm_i = 1'h1;
        cyc(1);
        alarm_arm_i = 1'h0;
    endtask : arm

    task automatic complete_run();
        if (n_fail == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    // ceiling: one full second of fast crystal plus some margin
    always @(posedge mclk_i) begin
        cyc_cnt++;
        if (cyc_cnt == 90000) begin
            n_fail++;
            $display("MISMATCH %0t run timed out", $time);
            complete_run();
        end
    end

    // -----------------------------
    // scenarios
    // -----------------------------
    initial begin
        cyc(6);
        sys_rst_i = 1'h0;
        cyc(3);
        chk(time_o, TIME_RST, "time after reset");
        chk({event_flag_o, alarm_flag_o, backup_mode_o, serial_enable_o, tamper_detect_oe_o, irq_freq_oe_o},
            6'h04, "status after reset");
        chk({tamper_detect_out_o, irq_freq_o}, 2'h0, "open drain data");
        for (i = 0; i < 4; i++) begin
            t_base = '{sec: 6'(rnd() % 60), min: 6'(rnd() % 60), hour: 5'(rnd() % 24), date: 5'(rnd() % 28 + 1),
                       month: 4'(rnd() % 12 + 1), year: 7'(rnd() % 99), dow: 3'(rnd() % 7)};
            load(t_base);
            chk(time_o, t_base, "time load");
        end
        t_base = '{sec: 6'h3b, min: 6'h3b, hour: 5'h17, date: 5'h1c, month: 4'h2, year: 7'h18, dow: 3'h6};
        load(t_base);
        xtal_run = 1'h1;
        cyc(2 * SEC_DIV - 2);
        chk(time_o, t_base, "one tick short");
        cyc(2);
        xtal_run = 1'h0;
        cyc(8);
        chk(time_o, next_sec(t_base), "leap day rollover");
        // crystal parked a whole second past the period start, so the window is shut
        sample_rate_i = SMP_QHZ;
        tamper_input_i = 1'h1;
        cyc(24);
        chk(event_flag_o, 1'h0, "input outside window");
        tamper_input_i = 1'h0;
        cyc(4);
        sample_rate_i = SMP_ALWAYS;
        for (i = 0; i < 4; i++) begin
            thr = (i == 0) ? 0 : (i == 1) ? FILT1_TICKS : (i == 2) ? FILT2_TICKS : FILT3_TICKS;
            tamper_filter_select_i = 2'(i);
            detect_out_enable_i = i[0];
            // no second tick here; freeze only exercised while flag is held
            freeze_enable_i = i[1];
            xtal_run = 1'h1;
            tamper_input_i = 1'h1;
            if (thr > 0) begin
                cyc(2 * thr - 8);
                chk(event_flag_o, 1'h0, "early event");
            end
            cyc(24);
            chk(event_flag_o, 1'h1, "event flag");
            chk(tamper_detect_oe_o, i[0], "detect pin");
            tamper_input_i = 1'h0;
            cyc(8);
            chk(tamper_detect_oe_o, i[0], "detect pin held");
            clr_flags();
            chk({tamper_detect_oe_o, event_flag_o}, 2'h0, "flag cleared");
        end
        tamper_filter_select_i = 2'h0;
        freeze_enable_i = 1'h0;
        event_enable_i = 1'h0;
        tamper_input_i = 1'h1;
        cyc(24);
        chk(event_flag_o, 1'h0, "disabled input");
        tamper_input_i = 1'h0;
        vdd_mv = 2500;
        cyc(8);
        event_enable_i = 1'h1;
        chk(backup_mode_o, 1'h0, "one condition only");
        vdd_mv = 2100;
        cyc(8);
        chk({backup_mode_o, serial_enable_o}, 2'h2, "backup entry");
        tamper_input_i = 1'h1;
        cyc(24);
        chk(event_flag_o, 1'h0, "tamper off in backup");
        tamper_backup_option_i = 1'h1;
        cyc(24);
        chk(event_flag_o, 1'h1, "tamper on in backup");
        tamper_input_i = 1'h0;
        cyc(4);
        clr_flags();
        chk(event_flag_o, 1'h0, "backup flag cleared");
        vdd_mv = 2220;
        cyc(8);
        chk(backup_mode_o, 1'h1, "inside hysteresis");
        vdd_mv = 2240;
        cyc(8);
        chk({backup_mode_o, serial_enable_o}, 2'h1, "back by trip");
        bat_mv = 2100;
        vdd_mv = 2000;
        cyc(8);
        chk(backup_mode_o, 1'h1, "low battery entry");
        vdd_mv = 2160;
        cyc(8);
        chk(backup_mode_o, 1'h0, "back by battery");
        alarm_time_i = '{sec: 6'h1e, min: 6'h05, hour: 5'h07, date: 5'h15, month: 4'h3, year: 7'h00, dow: 3'h2};
        alarm_field_enable_i = 6'h21;
        t_base = alarm_time_i;
        t_base.sec = 6'h0a;
        t_hit = alarm_time_i;
        t_hit.min = 6'h2a;
        irq_enable_i = 1'h1;
        load(t_hit);
        cyc(4);
        chk(alarm_flag_o, 1'h0, "not armed");
        load(t_base);
        arm();
        load(t_hit);
        cyc(4);
        chk(alarm_flag_o, 1'h1, "alarm hit");
        chk(irq_freq_oe_o, 1'h1, "irq pin low");
        irq_enable_i = 1'h0;
        cyc(1);
        chk(irq_freq_oe_o, 1'h0, "irq masked");
        clr_flags();
        load(t_base);
        load(t_hit);
        cyc(4);
        chk(alarm_flag_o, 1'h0, "single shot");
        alarm_repeat_i = 1'h1;
        arm();
        t_exp = t_hit;
        t_exp.dow = 3'h4;
        load(t_exp);
        cyc(4);
        chk(alarm_flag_o, 1'h0, "weekday mismatch");
        for (i = 0; i < 2; i++) begin
            load(t_base);
            load(t_hit);
            cyc(4);
            chk(alarm_flag_o, 1'h1, "repeat hit");
            clr_flags();
        end
        xtal_run = 1'h1;
        // each select step above the crystal halves the rate
        for (thr = 1; thr < 3; thr++) begin
            freq_output_select_i = 4'(thr);
            cyc(4);
            nt = 0;
            for (i = 0; i < 32; i++) begin
                prev = irq_freq_oe_o;
                cyc(1);
                nt += (irq_freq_oe_o !== prev) ? 1 : 0;
            end
            chk(32'(nt), 32'(32 >> (thr - 1)), "crystal on shared pin");
        end
        xtal_run = 1'h0;
        freq_output_select_i = FREQ_OUTPUT_IRQ;
        irq_enable_i = 1'h1;
        load(t_base);
        load(t_hit);
        cyc(4);
        chk(irq_freq_oe_o, 1'h1, "back to interrupt");
        complete_run();
    end
endmodule : rtc_event_alarm_power_switch_bench
